/* File: hw/chan_seq_defs.vh */
`ifndef CHAN_SEQ_DEFS_VH
`define CHAN_SEQ_DEFS_VH
// Opcodes
`define OP_HALT_IO      8'h9E
`define OP_TEST_CHANNEL 8'h9F
// Operand address fields, bit 0 is the least significant of 24
`define CHAN_HI         10
`define CHAN_LO         8
`define UNIT_HI         7
`define UNIT_LO         0
// Register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_IRQ_STAT    4'h8
`define REG_IRQ_MASK    4'hC
// Control register fields
`define CTRL_GO         0
`define CTRL_SUPV       1
`define CTRL_OP_LSB     8
`define CTRL_OPA_LSB    16
// Interrupt status bits
`define IRQ_DONE        0
`define IRQ_PRIV        1
// Reset values
`define CC_RST          2'h0
`define MASK_RST        2'h0
`endif

/* File: hw/op_decode.v */
`include "chan_seq_defs.vh"
// Classifies the fetched opcode
module op_decode (
  // Opcode in
  input  wire [7:0] opcode_i,
  // Class out
  output wire       is_halt_o,
  output wire       is_test_o
);
  // Both instructions use the storage-immediate format
  assign is_halt_o = (opcode_i == `OP_HALT_IO);
  assign is_test_o = (opcode_i == `OP_TEST_CHANNEL);
endmodule // op_decode

/* File: hw/chan_seq.v */
// The register addresses and the Avalon-MM register port are this design's own decisions.
`include "chan_seq_defs.vh"
module chan_seq (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  // Avalon-MM slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  // Channel side
  output reg  [7:0]  chan_select_o,
  output reg  [7:0]  unit_addr_o,
  output reg         halt_cmd_o,
  input  wire [1:0]  condition_code_i,
  input  wire        release_i,
  // Processor side
  output reg         end_op_o,
  output reg         irq_o
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_ENDOP = 2'h2;

  reg  [1:0]  state_r;
  reg  [7:0]  op_r;
  reg  [23:0] opa_r;
  reg         supv_r;
  reg  [1:0]  cc_r;
  reg         priv_r;
  reg  [1:0]  irq_stat_r;
  reg  [1:0]  irq_mask_r;
  reg         busy_r;
  reg         go_p;
  reg  [2:0]  rel_s;
  reg         rel_lvl_r;
  reg         set_done;
  reg         set_priv;
  wire        is_halt;
  wire        is_test;
  wire [2:0]  chan_num;
  wire        rel_lvl;

  op_decode u_dec (
    .opcode_i  (op_r),
    .is_halt_o (is_halt),
    .is_test_o (is_test)
  );

  // Operand bit n is vector bit n
  assign chan_num = opa_r[`CHAN_HI:`CHAN_LO];
  // Filtered release level, both edges debounced alike
  assign rel_lvl = rel_lvl_r;

  // Release comes from the channel domain
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      rel_s     <= 3'h0;
      rel_lvl_r <= 1'b0;
    end
    else
    begin
      rel_s <= {rel_s[1:0], release_i};
      // A change counts once the last two stages agree
      if (rel_s[2] == rel_s[1])
        rel_lvl_r <= rel_s[2];
    end
  end

  // Bus slave: one wait cycle, answer on the second edge
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      op_r              <= 8'h0;
      opa_r             <= 24'h0;
      supv_r            <= 1'b0;
      irq_mask_r        <= `MASK_RST;
      go_p              <= 1'b0;
    end
    else
    begin
      go_p <= 1'b0;
      if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
        avs_waitrequest_o <= 1'b0;
      else
        avs_waitrequest_o <= 1'b1;
      if (avs_write_i & avs_waitrequest_o)
      begin
        case (avs_address_i)
          `REG_CTRL:
          begin
            if (!busy_r)
            begin
              supv_r <= avs_writedata_i[`CTRL_SUPV];
              op_r   <= avs_writedata_i[`CTRL_OP_LSB+7:`CTRL_OP_LSB];
              go_p   <= avs_writedata_i[`CTRL_GO];
            end
          end
          `REG_IRQ_MASK: irq_mask_r <= avs_writedata_i[1:0];
          default: ;
        endcase
      end
      if (avs_read_i & avs_waitrequest_o)
      begin
        case (avs_address_i)
          `REG_CTRL:     avs_readdata_o <= {op_r, 3'h0, priv_r, cc_r, supv_r, busy_r, 8'h0, op_r};
          `REG_STATUS:   avs_readdata_o <= {8'h0, opa_r};
          `REG_IRQ_STAT: avs_readdata_o <= {30'h0, irq_stat_r};
          `REG_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask_r};
          default:       avs_readdata_o <= 32'h0;
        endcase
      end
      // Operand address register sits at offset 4 for writes
      if (avs_write_i & avs_waitrequest_o & (avs_address_i == `REG_STATUS) & !busy_r)
        opa_r <= avs_writedata_i[23:0];
    end
  end

  // Instruction sequencer
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_r       <= ST_IDLE;
      chan_select_o <= 8'h0;
      unit_addr_o   <= 8'h0;
      halt_cmd_o    <= 1'b0;
      cc_r          <= `CC_RST;
      priv_r        <= 1'b0;
      end_op_o      <= 1'b0;
      busy_r        <= 1'b0;
      set_done      <= 1'b0;
      set_priv      <= 1'b0;
    end
    else
    begin
      end_op_o <= 1'b0;
      set_done <= 1'b0;
      set_priv <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (go_p & (is_halt | is_test) & !rel_lvl)
          begin
            if (!supv_r)
            begin
              priv_r   <= 1'b1;
              set_priv <= 1'b1;
            end
            else
            begin
              priv_r        <= 1'b0;
              busy_r        <= 1'b1;
              chan_select_o <= 8'h01 << chan_num;
              // Unit address only travels with a halt
              unit_addr_o   <= is_halt ? opa_r[`UNIT_HI:`UNIT_LO] : 8'h0;
              halt_cmd_o    <= is_halt;
              state_r       <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          // Channel settles codes 0-3 on its own side; we only latch
          if (rel_lvl)
          begin
            cc_r          <= condition_code_i;
            chan_select_o <= 8'h0;
            halt_cmd_o    <= 1'b0;
            unit_addr_o   <= 8'h0;
            state_r       <= ST_ENDOP;
          end
        end
        ST_ENDOP:
        begin
          // Wait for release to fall before the next instruction
          if (!rel_lvl)
          begin
            end_op_o <= 1'b1;
            busy_r   <= 1'b0;
            set_done <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Sticky events; read of status clears, set wins
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      irq_stat_r <= 2'h0;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= ((avs_read_i & avs_waitrequest_o & (avs_address_i == `REG_IRQ_STAT))
                     ? 2'h0 : irq_stat_r) | {set_priv, set_done};
      irq_o      <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule // chan_seq

/* File: verif/chan_seq_props.sv */
module chan_seq_chk (
  // Clock and bus
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  // Channel side
  input wire logic [7:0] chan_select_o,
  input wire logic [7:0] unit_addr_o,
  input wire logic       halt_cmd_o,
  input wire logic       release_i,
  input wire logic       end_op_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Select must fall soon after release, allowing for the sync
  sequence sel_gone;
    ##[1:6] chan_select_o == 8'h00;
  endsequence
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  sel_onehot_a: assert property ($onehot0(chan_select_o))
    else $error("select not one-hot");
  halt_sel_a: assert property (halt_cmd_o |-> chan_select_o != 8'h00)
    else $error("halt without select");
  test_unit_a: assert property (chan_select_o != 8'h00 && !halt_cmd_o
    |-> unit_addr_o == 8'h00) else $error("unit address on test");
  rel_drop_a: assert property ($rose(release_i) && chan_select_o != 8'h00
    |-> sel_gone) else $error("select held after release");
  sel_hold_a: assert property (chan_select_o != 8'h00 && !release_i
    |=> $stable(chan_select_o)) else $error("select moved early");
  eop_once_a: assert property (end_op_o |=> !end_op_o)
    else $error("end-op too long");
  eop_idle_a: assert property (end_op_o |-> chan_select_o == 8'h00
    && !release_i) else $error("end-op before release");
endmodule // chan_seq_chk
bind chan_seq chan_seq_chk u_chk (.mclk_i, .sys_rst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .chan_select_o, .unit_addr_o, .halt_cmd_o, .release_i, .end_op_o);

/* File: verif/chan_model.sv */
module chan_model (
  // Processor side
  input  wire logic       mclk_i,
  input  wire logic [7:0] chan_select_i,
  input  wire logic       halt_cmd_i,
  // Channel state set by the bench
  input  wire logic       pend_i,
  input  wire logic       busy_i,
  input  wire logic       avail_i,
  input  wire logic       slow_i,
  // Answer
  output logic [1:0]      condition_code_o = 2'h0,
  output logic            release_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] code;
  int         cnt = 0;
  // Code from channel state; the bench sets that state before each case
  always @*
    if (halt_cmd_i)
      code = pend_i ? 2'h0 : busy_i ? 2'h2 : !avail_i ? 2'h3 : 2'h1;
    else
      code = pend_i ? 2'h1 : busy_i ? 2'h2 : 2'h0;
  // Code line toggles when idle so no stale value passes
  always @(posedge mclk_i)
  begin
    cnt <= |chan_select_i ? cnt + 1 : 0;
    release_o <= |chan_select_i && cnt >= (slow_i ? 9 : 1);
    condition_code_o <= |chan_select_i && cnt >= 1 ? code : ~condition_code_o;
  end
endmodule // chan_model

/* File: verif/test_channel_halt_and_test_sequencer.sv */
module test_channel_halt_and_test_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, rst = 1, rd = 0, wr = 0, pend = 0, busy = 0, avail = 1, slow = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [7:0]  sel, unit;
  logic [1:0]  cc;
  logic        wt, hc, rel, eop, irq;
  int          fails = 0, compares = 0;
  always #4 mclk = ~mclk;
  chan_seq uut (.mclk_i(mclk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .chan_select_o(sel), .unit_addr_o(unit), .halt_cmd_o(hc), .condition_code_i(cc),
    .release_i(rel), .end_op_o(eop), .irq_o(irq));
  chan_model pm (.mclk_i(mclk), .chan_select_i(sel), .halt_cmd_i(hc), .pend_i(pend),
    .busy_i(busy), .avail_i(avail), .slow_i(slow), .condition_code_o(cc), .release_o(rel));
  task chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task lim(int n);
    if (n > 40)
    begin
      fails++;
      close_out;
    end
  endtask
  // Request held until waitrequest is seen low
  task bus(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    while (wt !== 1'b0)
    begin
      @(posedge mclk);
      lim(n++);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Wait for select (k=0) or end-op (k=1)
  task w8(bit k);
    int n;
    n = 0;
    while ((k ? eop : |sel) !== 1'b1)
    begin
      @(posedge mclk);
      lim(n++);
    end
  endtask
  task halt_cases;
    for (int i = 0; i < 4; i++)
    begin
      pend <= i == 0;
      busy <= i == 1;
      avail <= i != 2;
      slow <= i[0];
      bus(1'b1, 4'h4, {21'h0, 3'(i * 2 + 1), 8'hA0 + 8'(i)});
      bus(1'b1, 4'h0, 32'h9E03);
      w8(1'b0);
      chk("select", 32'h1 << (i * 2 + 1), {24'h0, sel});
      chk("unit", 32'hA0 + i, {24'h0, unit});
      chk("halt", 32'h1, {31'h0, hc});
      w8(1'b1);
      chk("select off", 32'h0, {24'h0, sel});
      bus(1'b0, 4'h8, 32'h0);
      chk("done", 32'h1, q);
      bus(1'b0, 4'h0, 32'h0);
      chk("halt code", 32'(i == 1 ? 2 : i == 2 ? 3 : i == 3 ? 1 : 0), {30'h0, q[19:18]});
    end
  endtask
  task tch_case;
    bus(1'b1, 4'h4, 32'h2FF);
    for (int j = 0; j < 3; j++)
    begin
      pend <= j == 0;
      busy <= j == 1;
      avail <= 1'b1;
      slow <= j[0];
      bus(1'b1, 4'h0, 32'h9F03);
      w8(1'b0);
      chk("tch select", 32'h4, {24'h0, sel});
      chk("tch unit", 32'h0, {24'h0, unit});
      chk("tch halt", 32'h0, {31'h0, hc});
      w8(1'b1);
      chk("tch select off", 32'h0, {24'h0, sel});
      bus(1'b0, 4'h0, 32'h0);
      chk("tch code", 32'(j == 0 ? 1 : j == 1 ? 2 : 0), {30'h0, q[19:18]});
    end
  endtask
  task priv_case;
    bus(1'b0, 4'h8, 32'h0);
    bus(1'b1, 4'hC, 32'h3);
    bus(1'b1, 4'h0, 32'h9E01);
    repeat (6) @(posedge mclk);
    chk("priv select", 32'h0, {24'h0, sel});
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, 4'h8, 32'h0);
    chk("priv stat", 32'h2, q);
    bus(1'b0, 4'h0, 32'h0);
    chk("priv flag", 32'h1, {31'h0, q[20]});
    bus(1'b1, 4'h0, 32'h9D03);
    repeat (6) @(posedge mclk);
    chk("irq off", 32'h0, {31'h0, irq});
    chk("other op", 32'h0, {24'h0, sel});
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    chk("wait idle", 32'h1, {31'h0, wt});
    halt_cases;
    tch_case;
    priv_case;
    close_out;
  end
endmodule // test_channel_halt_and_test_sequencer
